// [bench/axi_master_model.sv]
/* axi4-lite master model for the alu register port.
 assumes one call at a time, after reset. */
`timescale 1ns/100ps
module axi_master_model (
	input wire aclk,
	output reg [7:0] s_axi_awaddr,
	output reg s_axi_awvalid,
	input wire s_axi_awready,
	output reg [31:0] s_axi_wdata,
	output reg [3:0] s_axi_wstrb,
	output reg s_axi_wvalid,
	input wire s_axi_wready,
	input wire s_axi_bvalid,
	output reg s_axi_bready,
	output reg [7:0] s_axi_araddr,
	output reg s_axi_arvalid,
	input wire s_axi_arready,
	input wire s_axi_rvalid,
	output reg s_axi_rready
);
	// idle bus from time zero
	initial {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid, s_axi_bready} = 0;
	initial {s_axi_araddr, s_axi_arvalid, s_axi_rready} = 0;
	// write: both halves offered together, each let go once taken
	task wr(input [7:0] a, input [31:0] d, input [3:0] s);
		@(posedge aclk);
		{s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, s};
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 0;
			if (s_axi_wready) s_axi_wvalid <= 0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 0;
	endtask
	// read: address held until taken, answer taken with rvalid
	task rd(input [7:0] a);
		@(posedge aclk);
		{s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'b11};
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 0;
		end while (!s_axi_rvalid);
		s_axi_rready <= 0;
	endtask
endmodule // axi_master_model

// [bench/byte_alu_checker.sv]
/* checker: answer timing of the alu register port.
 assumes binding onto byte_alu_bit_ops. */
`timescale 1ns/100ps
module byte_alu_checker (
	input wire aclk,
	input wire aresetn,
	input wire clk_en,
	input wire s_axi_awvalid,
	input wire s_axi_awready,
	input wire s_axi_wvalid,
	input wire s_axi_wready,
	input wire [1:0] s_axi_bresp,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire [1:0] s_axi_rresp,
	input wire s_axi_rvalid,
	input wire s_axi_rready
);
	// by default frozen cycles and reset carry no duty; a_frz_ready still checks frozen cycles
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn || !clk_en);
	a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("b dropped");
	a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid) else $error("r dropped");
	a_b_lat: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
		else $error("b late");
	a_frz_ready: assert property (disable iff (!aresetn) !clk_en |-> !s_axi_awready && !s_axi_wready && !s_axi_arready)
		else $error("ready while frozen");
	a_r_lat: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("r late");
	a_ar_gate: assert property (s_axi_arready != s_axi_rvalid) else $error("ar gate");
	a_w_gate: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("w gate");
	a_b_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("b twice");
	a_r_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("r twice");
	c_write: cover property (s_axi_bvalid && s_axi_bready);
	c_read: cover property (s_axi_rvalid && s_axi_rready);
	c_slverr: cover property (s_axi_rvalid && s_axi_rresp == 2'b10);
	c_wr_slverr: cover property (s_axi_bvalid && s_axi_bready && s_axi_bresp == 2'b10);
	c_frozen: cover property (disable iff (!aresetn) !clk_en && s_axi_awvalid && s_axi_wvalid);
endmodule // byte_alu_checker
bind byte_alu_bit_ops byte_alu_checker chk_u (.*);

// [bench/testbench.sv]
/* bench: random alu operations of every kind, read back and compared.
 assumes the master model and the bound checker. */
`timescale 1ns/100ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_mismatch++; \
	$display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module testbench;
	reg aclk = 0, aresetn = 0, clk_en = 1;
	wire [7:0] s_axi_awaddr, s_axi_araddr;
	wire [31:0] s_axi_wdata, s_axi_rdata;
	wire [3:0] s_axi_wstrb;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	wire s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	integer n_mismatch = 0, n_checks = 0, seed = 4, i;
	reg [33:0] exp_q[$], e_w;
	reg [1:0] exp_b[$], e_b, hold;
	reg [8:0] s;
	reg [7:0] a, k, v, r, res = 0;
	reg [4:0] n;
	reg [2:0] f, op, b;
	reg d;
	byte_alu_bit_ops dut_u (.*);
	axi_master_model bus_u (.*);
	// 100 mhz clock
	initial forever #5 aclk = ~aclk;
	// each read answer and each write response against the oldest note
	always @(posedge aclk) begin
		if (s_axi_rvalid && s_axi_rready) begin
			e_w = exp_q.pop_front();
			`CHK({s_axi_rresp, s_axi_rdata}, e_w)
		end
		if (s_axi_bvalid && s_axi_bready) begin
			e_b = exp_b.pop_front();
			`CHK(s_axi_bresp, e_b)
		end
	end
	// note an expected word, then read it
	task rd_exp(input [7:0] ad, input [33:0] e);
		exp_q.push_back(e);
		bus_u.rd(ad);
	endtask
	// note the expected response, then write
	task wr_exp(input [7:0] ad, input [31:0] dt, input [3:0] st, input [1:0] e);
		exp_b.push_back(e);
		bus_u.wr(ad, dt, st);
	endtask
	task complete_run;
		if (exp_q.size() != 0 || exp_b.size() != 0)
			n_mismatch++;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// hang guard, run needs about 2500 cycles
	initial begin
		#200000;
		n_mismatch++;
		complete_run;
	end
	// reset values, unmapped read, then operations with flags preset
	initial begin
		repeat (20) @(posedge aclk);
		aresetn <= 1;
		rd_exp(8'h08, 0);
		rd_exp(8'h0C, 0);
		rd_exp(8'h20, 34'h2_0000_0000);
		// the result register is read-only: refused and left at zero
		wr_exp(8'h10, 32'h0000_00A5, 4'hF, 2'b10);
		rd_exp(8'h10, 0);
		for (i = 0; i < 64; i++) begin
			op = 3'(i % 8);
			{a, k, v, b, d, f} = 31'($random(seed));
			n = 5'($random(seed));
			hold = 2'($random(seed));
			wr_exp(8'h08, {24'h0, a}, 4'hF, 2'b00);
			wr_exp(8'h0C, {29'h0, f}, 4'hF, 2'b00);
			wr_exp(8'h80 + {n, 2'b00}, {24'h0, v}, 4'hF, 2'b00);
			wr_exp(8'h04, {19'h0, n, k}, 4'h3, 2'b00);
			wr_exp(8'h00, {25'h0, b, d, op}, 4'h1, 2'b00);
			// go is offered while the block is frozen for zero to three cycles
			fork
				wr_exp(8'h00, 32'h8000_0000, 4'h8, 2'b00);
				begin
					clk_en <= 0;
					repeat (hold + 1) @(posedge aclk);
					clk_en <= 1;
				end
			join
			s = a + (op == 1 ? v : k);
			r = op[1] ? a & (op[0] ? k : v) : s[7:0];
			if (op < 2) f = {r == 0, a[3:0] + (op == 1 ? v[3:0] : k[3:0]) > 15, s[8]};
			else if (op < 4) f[2] = r == 0;
			if (op > 5) r = res; // codes six and seven change nothing
			else if (op > 3) begin
				v[b] = op[0];
				r = v;
			end else if (op == 0 || op == 3 || !d) a = r;
			else v = r;
			res = r;
			rd_exp(8'h08, {26'h0, a});
			rd_exp(8'h0C, {31'h0, f});
			rd_exp(8'h80 + {n, 2'b00}, {26'h0, v});
			rd_exp(8'h10, {26'h0, res});
		end
		@(posedge aclk);
		complete_run;
	end
endmodule // testbench

// [logic/byte_alu_bit_ops.v]
/*
 byte_alu_bit_ops: 8-bit alu datapath for six core operations with an axi4-lite register window.
 assumes a single 100 mhz clock, synchronous active-low reset, and an axi master that keeps the
 channel rules; the 128-entry data file lives here and is reachable at byte offset 0x80 upward.
 the bus window shows only the first 32 file entries; operations reach all 128 by the operand address.
 the data file is not cleared by reset, so software writes an entry before an operation reads it.
 an operation runs on a go write and uses the control and operand fields held before that write.
 while clk_en is low every register holds and the port shows no ready, so nothing is taken.
*/
//
// Function
// RULE_01 - literal add sums the accumulator and an 8-bit literal into the accumulator and updates carry, nibble carry and zero.
// RULE_02 - file add sums the accumulator and the file entry at a 7-bit address, sends it to the chosen destination and updates all three flags.
// RULE_03 - destination select 0 writes the result to the accumulator and leaves the file entry alone.
// RULE_04 - destination select 1 writes the result to the file entry and leaves the accumulator alone.
// RULE_05 - file and combines accumulator and file entry bitwise, sends it to the chosen destination and updates only zero.
// RULE_06 - literal and combines accumulator and literal bitwise into the accumulator and updates only zero.
// RULE_07 - bit clear forces the indexed bit of the file entry to zero and keeps all flags.
// RULE_08 - bit set forces the indexed bit of the file entry to one and keeps all flags.
// RULE_09 - zero is set for a zero result, carry from bit 7 out and nibble carry from bit 3 out on additions.
// RULE_10 - bit clear and bit set read, modify and write the file entry so the other seven bits keep their values.
`timescale 1ns/100ps
`include "byte_alu_defs.vh"

module byte_alu_bit_ops (
	input wire aclk,
	input wire aresetn,
	input wire clk_en,
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready
);

	// data file and working register
	reg [7:0] file_mem [0:`FILE_DEPTH-1];
	reg [7:0] acc_ff;
	reg [2:0] op_ff;
	reg dest_ff;
	reg [2:0] bit_idx_ff;
	reg [7:0] lit_ff;
	reg [6:0] addr_ff;
	// status flags and last result
	reg carry_ff;
	reg nibble_carry_flag_ff;
	reg zero_ff;
	reg [7:0] result_ff;
	// write halves held until both have arrived
	reg [7:0] awaddr_ff;
	reg aw_held_ff;
	reg [31:0] wdata_ff;
	reg [3:0] wstrb_ff;
	reg w_held_ff;

	// datapath nets
	wire [7:0] file_q;
	wire [7:0] add_opnd;
	wire [8:0] sum_full;
	wire [4:0] sum_low;
	wire [7:0] and_lit;
	wire [7:0] and_file;
	wire [7:0] bit_mask;
	// read words and write decode
	wire [31:0] ctrl_word;
	wire [31:0] opnd_word;
	wire [31:0] stat_word;
	wire wr_fire;
	wire go;
	wire wr_file;
	wire wr_ok;

	// operation decode outputs
	reg [7:0] alu_res;
	reg alu_to_acc;
	reg alu_to_file;
	reg alu_flags_all;
	reg alu_flag_zero;
	reg alu_valid;

	// operand fetch: literal add uses the held literal, the other adds the addressed file entry
	assign file_q = file_mem[addr_ff];
	assign add_opnd = (op_ff == `OP_ADD_LIT) ? lit_ff : file_q;
	// nine-bit sum gives the carry out of bit 7, five-bit low sum the carry out of bit 3
	assign sum_full = {1'b0, acc_ff} + {1'b0, add_opnd}; // RULE_09
	assign sum_low = {1'b0, acc_ff[`NIB_MSB:0]} + {1'b0, add_opnd[`NIB_MSB:0]}; // RULE_09
	// both logic results are formed every cycle, the decode below picks one
	assign and_lit = acc_ff & lit_ff;
	assign and_file = acc_ff & file_q;

	// one-hot mask for the indexed bit
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi = gi + 1) begin : g_mask
			assign bit_mask[gi] = (bit_idx_ff == gi);
		end
	endgenerate

	// operation select: result, destination and flag update
	always @* begin
		alu_res = `BYTE_ZERO;
		alu_to_acc = 1'b0;
		alu_to_file = 1'b0;
		alu_flags_all = 1'b0;
		alu_flag_zero = 1'b0;
		alu_valid = 1'b1;
		// one arm per operation; codes six and seven leave every register alone
		case (op_ff)
			`OP_ADD_LIT: begin
				alu_res = sum_full[7:0]; // RULE_01
				alu_to_acc = 1'b1;
				alu_flags_all = 1'b1;
			end
			`OP_ADD_FILE: begin
				alu_res = sum_full[7:0]; // RULE_02
				alu_to_acc = ~dest_ff; // RULE_03
				alu_to_file = dest_ff; // RULE_04
				alu_flags_all = 1'b1;
			end
			`OP_AND_FILE: begin
				alu_res = and_file; // RULE_05
				alu_to_acc = ~dest_ff; // RULE_03
				alu_to_file = dest_ff; // RULE_04
				alu_flag_zero = 1'b1;
			end
			`OP_AND_LIT: begin
				alu_res = and_lit; // RULE_06
				alu_to_acc = 1'b1;
				alu_flag_zero = 1'b1;
			end
			`OP_BIT_CLR: begin
				alu_res = file_q & ~bit_mask; // RULE_07 RULE_10
				alu_to_file = 1'b1;
			end
			`OP_BIT_SET: begin
				alu_res = file_q | bit_mask; // RULE_08 RULE_10
				alu_to_file = 1'b1;
			end
			default: begin
				alu_valid = 1'b0; // unused codes do nothing
			end
		endcase
	end

	// write channel: address and data taken in either order, response after both
	// readies stay low while frozen, so no half is shown as taken and then dropped
	assign s_axi_awready = clk_en & ~aw_held_ff & ~s_axi_bvalid;
	assign s_axi_wready = clk_en & ~w_held_ff & ~s_axi_bvalid;
	// both halves held and no response pending: the write acts on this edge
	assign wr_fire = aw_held_ff & w_held_ff & ~s_axi_bvalid;
	// the top address bit opens the file window, the rest is the register map
	assign wr_file = awaddr_ff[`WIN_SEL];
	assign wr_ok = wr_file | (awaddr_ff == `REG_CTRL) | (awaddr_ff == `REG_OPND) | (awaddr_ff == `REG_ACC)
		| (awaddr_ff == `REG_STAT);
	// an operation starts only on a go bit written through the top byte lane
	assign go = wr_fire & (awaddr_ff == `REG_CTRL) & wstrb_ff[`LANE_GO] & wdata_ff[`CTRL_GO];

	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_ff <= 1'b0;
			w_held_ff <= 1'b0;
			awaddr_ff <= `BYTE_ZERO;
			wdata_ff <= `WORD_ZERO;
			wstrb_ff <= `STRB_ZERO;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RESP_OKAY;
		end else if (clk_en) begin
			// hold each half as it arrives
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_ff <= 1'b1;
				awaddr_ff <= {s_axi_awaddr[7:2], 2'b00};
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_ff <= 1'b1;
				wdata_ff <= s_axi_wdata;
				wstrb_ff <= s_axi_wstrb;
			end
			// answer once both halves are in, clear the answer when it is taken
			if (wr_fire) begin
				aw_held_ff <= 1'b0;
				w_held_ff <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// control, operand and status registers plus execution of one operation
	always @(posedge aclk) begin
		if (!aresetn) begin
			acc_ff <= `BYTE_ZERO;
			op_ff <= `OP_ADD_LIT;
			dest_ff <= 1'b0;
			bit_idx_ff <= `BIT_IDX_RST;
			lit_ff <= `BYTE_ZERO;
			addr_ff <= `ADDR_RST;
			carry_ff <= 1'b0;
			nibble_carry_flag_ff <= 1'b0;
			zero_ff <= 1'b0;
			result_ff <= `BYTE_ZERO;
		end else if (clk_en) begin
			// control fields through the low lane
			if (wr_fire && awaddr_ff == `REG_CTRL && wstrb_ff[`LANE_LOW]) begin
				op_ff <= wdata_ff[`CTRL_OP_HI:`CTRL_OP_LO];
				dest_ff <= wdata_ff[`CTRL_DEST];
				bit_idx_ff <= wdata_ff[`CTRL_BIT_HI:`CTRL_BIT_LO];
			end
			// operand register, each field through its own lane
			if (wr_fire && awaddr_ff == `REG_OPND) begin
				if (wstrb_ff[`LANE_LOW])
					lit_ff <= wdata_ff[`OPND_LIT_HI:`OPND_LIT_LO];
				if (wstrb_ff[`LANE_ADDR])
					addr_ff <= wdata_ff[`OPND_ADDR_HI:`OPND_ADDR_LO];
			end
			// working register and flags written by software
			if (wr_fire && awaddr_ff == `REG_ACC && wstrb_ff[`LANE_LOW])
				acc_ff <= wdata_ff[`BYTE_HI:0];
			if (wr_fire && awaddr_ff == `REG_STAT && wstrb_ff[`LANE_LOW]) begin
				carry_ff <= wdata_ff[`ST_CARRY];
				nibble_carry_flag_ff <= wdata_ff[`ST_NIBBLE];
				zero_ff <= wdata_ff[`ST_ZERO];
			end
			// the go write uses the fields held before this write
			if (go && alu_valid) begin
				result_ff <= alu_res;
				if (alu_to_acc)
					acc_ff <= alu_res; // RULE_03
				// additions move all three flags, the logic operations only zero
				if (alu_flags_all) begin
					carry_ff <= sum_full[8]; // RULE_09
					nibble_carry_flag_ff <= sum_low[4]; // RULE_09
				end
				if (alu_flags_all || alu_flag_zero)
					zero_ff <= (alu_res == `BYTE_ZERO); // RULE_09
			end
		end
	end

	// data file: software window writes and operation write-back
	always @(posedge aclk) begin
		if (clk_en) begin
			// write-back of an operation, else a software write through the window
			if (go && alu_valid && alu_to_file)
				file_mem[addr_ff] <= alu_res; // RULE_04 RULE_10
			else if (wr_fire && wr_file && wstrb_ff[`LANE_LOW])
				file_mem[awaddr_ff[`WIN_IDX_HI:`WIN_IDX_LO]] <= wdata_ff[`BYTE_HI:0];
		end
	end

	// read word assembly
	assign ctrl_word = {25'h000_0000, bit_idx_ff, dest_ff, op_ff};
	assign opnd_word = {17'h0_0000, addr_ff, lit_ff};
	assign stat_word = {29'h0000_0000, zero_ff, nibble_carry_flag_ff, carry_ff};
	// no address is taken while frozen or while an answer waits
	assign s_axi_arready = clk_en & ~s_axi_rvalid;

	// read channel: one cycle to answer, held until rready
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= `WORD_ZERO;
			s_axi_rresp <= `RESP_OKAY;
		end else if (clk_en) begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= `RESP_OKAY;
				// file window first, then the register map
				if (s_axi_araddr[`WIN_SEL])
					s_axi_rdata <= {24'h00_0000, file_mem[s_axi_araddr[`WIN_IDX_HI:`WIN_IDX_LO]]};
				else begin
					case ({s_axi_araddr[7:2], 2'b00})
						`REG_CTRL: s_axi_rdata <= ctrl_word;
						`REG_OPND: s_axi_rdata <= opnd_word;
						`REG_ACC: s_axi_rdata <= {24'h00_0000, acc_ff};
						`REG_STAT: s_axi_rdata <= stat_word;
						`REG_RESULT: s_axi_rdata <= {24'h00_0000, result_ff};
						default: begin
							s_axi_rdata <= `WORD_ZERO;
							s_axi_rresp <= `RESP_SLVERR;
						end
					endcase
				end
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

endmodule // byte_alu_bit_ops

// [logic/byte_alu_defs.vh]
/*
 byte_alu_defs.vh: constants for the byte alu datapath and its axi4-lite register map.
 assumes it is included by bare name into the single design file.
*/
`ifndef BYTE_ALU_DEFS_VH
`define BYTE_ALU_DEFS_VH

// register byte offsets
`define REG_CTRL 8'h00
`define REG_OPND 8'h04
`define REG_ACC 8'h08
`define REG_STAT 8'h0C
`define REG_RESULT 8'h10
`define REG_FILE_BASE 8'h80

// operation codes in ctrl[2:0]
`define OP_ADD_LIT 3'h0
`define OP_ADD_FILE 3'h1
`define OP_AND_FILE 3'h2
`define OP_AND_LIT 3'h3
`define OP_BIT_CLR 3'h4
`define OP_BIT_SET 3'h5

// ctrl field positions
`define CTRL_OP_HI 2
`define CTRL_OP_LO 0
`define CTRL_DEST 3
`define CTRL_BIT_HI 6
`define CTRL_BIT_LO 4
`define CTRL_GO 31

// operand register fields
`define OPND_LIT_HI 7
`define OPND_LIT_LO 0
`define OPND_ADDR_HI 14
`define OPND_ADDR_LO 8

// status bit positions
`define ST_CARRY 0
`define ST_NIBBLE 1
`define ST_ZERO 2

// reset values and responses
`define BYTE_ZERO 8'h00
`define NIB_MSB 3
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`define FILE_DEPTH 128
`define WORD_ZERO 32'h0000_0000
`define STRB_ZERO 4'h0
`define BIT_IDX_RST 3'h0
`define ADDR_RST 7'h00

// byte lanes, file window bits and the data byte
`define LANE_LOW 0
`define LANE_ADDR 1
`define LANE_GO 3
`define WIN_SEL 7
`define WIN_IDX_HI 6
`define WIN_IDX_LO 2
`define BYTE_HI 7

`endif
